// ---- rtl/ssac_params.svh ----
`ifndef SSAC_PARAMS_SVH
`define SSAC_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (index = word number, byte address = index * 4)
// ----------------------------------------------------------------
`define SSAC_ACR_INDEX        8'h1d
`define SSAC_FLAG_INDEX       8'h1e
`define SSAC_ACR_RESET        8'h00
`define SSAC_FLAG_RESET       8'h00

// ----------------------------------------------------------------
// analog_control bit positions
// ----------------------------------------------------------------
`define SSAC_BIT_RAMP_DIR     7
`define SSAC_BIT_MODE_HIGH    6
`define SSAC_BIT_MODE_LOW     5
`define SSAC_BIT_ROUTE        4
`define SSAC_BIT_IRQ_EN       3
`define SSAC_BIT_CP2_PWR      2
`define SSAC_BIT_CP1_PWR      1
`define SSAC_BIT_ISRC_PWR     0

// ----------------------------------------------------------------
// Flag register bit positions (read: flag, write one: clear)
// ----------------------------------------------------------------
`define SSAC_BIT_FLAG_TWO     1
`define SSAC_BIT_FLAG_ONE     0

// ----------------------------------------------------------------
// Input synchroniser
// ----------------------------------------------------------------
`define SSAC_SYNC_INPUTS      3
`define SSAC_SYNC_CMP1        0
`define SSAC_SYNC_CMP2        1
`define SSAC_SYNC_EXTCAP      2

`endif

// ---- rtl/ssac_pkg.sv ----
package ssac_pkg;

  // ----------------------------------------------------------------
  // Conversion modes, in the order of their two-bit code
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSAC_MODE_MANUAL,      // Software drives the ramp direction
    SSAC_MODE_AUTO_DIS,    // Manual charge, discharge on flag two
    SSAC_MODE_OVF_CAP,     // Charge on overflow, stop on capture
    SSAC_MODE_CMP_CAP      // Charge on compare, stop on capture
  } ssac_mode_type;

  // ----------------------------------------------------------------
  // Whole state of the control block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ramp_direction;        // One sources, zero sinks
    logic        conv_mode_high;        // Mode code, high bit
    logic        conv_mode_low;         // Mode code, low bit
    logic        capture_route_select;  // Capture from flag two
    logic        comparator_irq_enable; // Gates the analog request
    logic        comparator_two_power;  // Comparator two powered
    logic        comparator_one_power;  // Comparator one powered
    logic        current_source_power;  // Ramp source powered
    logic        comparator_one_flag;   // Sticky rising edge, one
    logic        comparator_two_flag;   // Sticky rising edge, two
    logic        cmp1_prev;             // Last filtered level, one
    logic        cmp2_prev;             // Last filtered level, two
    logic        pready;                // Bus answer
    logic        pslverr;               // Bus error answer
    logic [31:0] prdata;                // Bus read data
    logic        ramp_source_en;        // Charge source on ramp pin
    logic        ramp_sink_en;          // Discharge device on pin
    logic        support_power;         // Shared support circuitry
    logic        capture_input;         // Timer capture source
    logic        analog_irq;            // Analog interrupt request
  } ssac_state_type;

endpackage

// ---- rtl/ssac_sync_if.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Filtered levels from the synchroniser to the control logic
// ----------------------------------------------------------------
interface ssac_sync_if #(
  parameter int WIDTH = 3
);
  logic [WIDTH-1:0] level;  // Debounced, clock-domain levels

  modport src (output level);
  modport dst (input  level);
endinterface

// ---- rtl/ssac_sync.sv ----
`timescale 1ns/1ns

// Three-stage synchroniser; a change is accepted once the second
// and third stages agree, so a one-cycle glitch is never counted.
module ssac_sync #(
  parameter int WIDTH = 3
) (
  input  logic             pclk,
  input  logic             presetn,
  input  logic [WIDTH-1:0] async_in,
  ssac_sync_if.src         sync_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] s1;      // First stage, read only by s2
    logic [WIDTH-1:0] s2;      // Second stage
    logic [WIDTH-1:0] s3;      // Third stage
    logic [WIDTH-1:0] stable;  // Accepted level
  } ssac_sync_state_type;

  ssac_sync_state_type state_reg;
  ssac_sync_state_type state_next;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("ssac_sync: WIDTH must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state: shift, accept where two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.s1     = async_in;
    state_next.s2     = state_reg.s1;
    state_next.s3     = state_reg.s2;
    state_next.stable = (state_reg.s2 & ~(state_reg.s2 ^ state_reg.s3)) |
                        (state_reg.stable & (state_reg.s2 ^ state_reg.s3));
  end

  // Register; reset to zero, i.e. comparators read low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out.level = state_reg.stable;

endmodule

// ---- rtl/ssac_top.sv ----
`timescale 1ns/1ns
`include "ssac_params.svh"

// Overview of operation
// (R1) Reset clears every control bit
// (R2) Control register at index 1d holds power bits
// (R3) Current source off: direction and mode ignored
// (R4) Direction one sources, zero sinks when powered
// (R5) Direction reads back hardware changes too
// (R6) Two mode bits select four conversion modes
// (R7) Manual mode: direction changes only on writes
// (R8) Auto discharge: flag two clears direction
// (R9) Overflow sets, capture clears direction
// (R10) Compare sets, capture clears direction
// (R11) Route bit picks flag two or pin
// (R12) Writing mode high bit sets route bit
// (R13) Flag-two capture stores timer count externally
// (R14) Software sets timer capture edge rising
// (R15) Irq enable: request while either flag set
// (R16) Analog request stays after capture flag cleared
// (R17) Each comparator power bit switches its comparator
// (R18) Source power bit powers source and discharge
// (R19) Support powered when any power bit set
// (R20) Software powers source, comparators, clears flags
// (R21) Flag two sets on rise, clears writing one
// (R22) Hardware changes at event edge, writes win
module ssac_top #(
  parameter int ADDR_W = 8
) (
  input  logic              pclk,
  input  logic              presetn,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [ADDR_W-1:0] paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic              comparator_one_out,
  input  logic              comparator_two_out,
  input  logic              external_capture_pin,
  input  logic              timer_overflow_flag,
  input  logic              compare_match_flag,
  input  logic              capture_event_flag,
  output logic              comparator_one_power_en,
  output logic              comparator_two_power_en,
  output logic              current_source_power_en,
  output logic              support_power_en,
  output logic              ramp_source_en,
  output logic              ramp_sink_en,
  output logic              timer_capture_input,
  output logic              analog_irq
);
  import ssac_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The highest register sits at byte 78, which seven address bits
  // can reach; the check below asks for at least eight.
  generate
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("ssac_top: ADDR_W must lie between 8 and 32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ACR_ADDR  =
    ADDR_W'({`SSAC_ACR_INDEX, 2'b00});     // Control word address
  localparam logic [ADDR_W-1:0] FLAG_ADDR =
    ADDR_W'({`SSAC_FLAG_INDEX, 2'b00});    // Flag word address

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ssac_state_type  state_reg;           // All registered state
  ssac_state_type  state_next;          // Its next value
  ssac_sync_if #(.WIDTH(`SSAC_SYNC_INPUTS)) sync_bus ();
  logic [`SSAC_SYNC_INPUTS-1:0] raw_in; // Pins from outside domain
  logic            cmp1_level;          // Filtered comparator one
  logic            cmp2_level;          // Filtered comparator two
  logic            extcap_level;        // Filtered capture pin
  logic            cmp1_rise;           // Rising edge, comparator one
  logic            cmp2_rise;           // Rising edge, comparator two
  logic            setup_phase;         // APB setup cycle
  logic            access_done;         // APB transfer completes
  logic            wr_acr;              // Write to control word
  logic            wr_flag;             // Write to flag word
  logic            addr_hit;            // Address is mapped
  logic [7:0]      acr_value;           // Control word as read
  logic [7:0]      flag_value;          // Flag word as read
  logic [7:0]      wbyte;               // Low write data byte
  ssac_mode_type   mode;                // Current conversion mode

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Comparator outputs and the capture pin are asynchronous.
  // Timer flags come from logic on pclk and are used directly.
  assign raw_in[`SSAC_SYNC_CMP1]   = comparator_one_out;
  assign raw_in[`SSAC_SYNC_CMP2]   = comparator_two_out;
  assign raw_in[`SSAC_SYNC_EXTCAP] = external_capture_pin;

  ssac_sync #(
    .WIDTH    (`SSAC_SYNC_INPUTS)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_in),
    .sync_out (sync_bus)
  );

  assign cmp1_level   = sync_bus.level[`SSAC_SYNC_CMP1];
  assign cmp2_level   = sync_bus.level[`SSAC_SYNC_CMP2];
  assign extcap_level = sync_bus.level[`SSAC_SYNC_EXTCAP];

  // Edge detect on the filtered levels only
  assign cmp1_rise = cmp1_level & ~state_reg.cmp1_prev;
  assign cmp2_rise = cmp2_level & ~state_reg.cmp2_prev;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // pready is registered, so every transfer has one wait-free
  // access cycle; the cost is the extra flop, kept for clean timing.
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & state_reg.pready;
  assign addr_hit    = (paddr == ACR_ADDR) || (paddr == FLAG_ADDR);
  assign wr_acr      = access_done & pwrite & (paddr == ACR_ADDR);
  assign wr_flag     = access_done & pwrite & (paddr == FLAG_ADDR);
  assign wbyte       = pwdata[7:0];

  // ----------------------------------------------------------------
  // Readable views
  // ----------------------------------------------------------------
  // Direction is read from state, hardware changes included
  always_comb begin
    acr_value                       = `SSAC_ACR_RESET;
    acr_value[`SSAC_BIT_RAMP_DIR]   = state_reg.ramp_direction;        // R5
    acr_value[`SSAC_BIT_MODE_HIGH]  = state_reg.conv_mode_high;
    acr_value[`SSAC_BIT_MODE_LOW]   = state_reg.conv_mode_low;
    acr_value[`SSAC_BIT_ROUTE]      = state_reg.capture_route_select;
    acr_value[`SSAC_BIT_IRQ_EN]     = state_reg.comparator_irq_enable;
    acr_value[`SSAC_BIT_CP2_PWR]    = state_reg.comparator_two_power;  // R2
    acr_value[`SSAC_BIT_CP1_PWR]    = state_reg.comparator_one_power;  // R2
    acr_value[`SSAC_BIT_ISRC_PWR]   = state_reg.current_source_power;  // R2
  end

  // Write-one-clear bits read the sticky flags, other bits zero
  always_comb begin
    flag_value                      = `SSAC_FLAG_RESET;
    flag_value[`SSAC_BIT_FLAG_TWO]  = state_reg.comparator_two_flag;
    flag_value[`SSAC_BIT_FLAG_ONE]  = state_reg.comparator_one_flag;
  end

  // Mode decode from the two stored bits
  assign mode = ssac_mode_type'({state_reg.conv_mode_high,
                                 state_reg.conv_mode_low});          // R6

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Bus answer: ready in the cycle after setup
    state_next.pready  = setup_phase;
    state_next.pslverr = setup_phase & ~addr_hit;
    if (setup_phase) begin
      if (pwrite || !addr_hit) begin
        state_next.prdata = 32'h0000_0000;
      end else if (paddr == ACR_ADDR) begin
        state_next.prdata = {24'h00_0000, acr_value};
      end else begin
        state_next.prdata = {24'h00_0000, flag_value};
      end
    end else begin
      // Zero outside the answer cycle, setup phase included
      state_next.prdata = 32'h0000_0000;
    end

    // Filtered level history for edge detect
    state_next.cmp1_prev = cmp1_level;
    state_next.cmp2_prev = cmp2_level;

    // Flags: a clear written in the same cycle loses to a new edge
    if (wr_flag && wbyte[`SSAC_BIT_FLAG_ONE]) begin
      state_next.comparator_one_flag = 1'b0;
    end
    if (wr_flag && wbyte[`SSAC_BIT_FLAG_TWO]) begin
      state_next.comparator_two_flag = 1'b0; // R21
    end
    if (cmp1_rise) begin
      state_next.comparator_one_flag = 1'b1;
    end
    if (cmp2_rise) begin
      state_next.comparator_two_flag = 1'b1; // R21
    end

    // Hardware steering of direction, only with source powered
    if (state_reg.current_source_power) begin // R3
      unique case (mode)
        SSAC_MODE_MANUAL: begin
          // Direction held until software rewrites it
          state_next.ramp_direction = state_reg.ramp_direction;     // R7
        end
        SSAC_MODE_AUTO_DIS: begin
          // Flag two setting ends the charge
          if (cmp2_rise) begin
            state_next.ramp_direction = 1'b0; // R8 R22
          end
        end
        SSAC_MODE_OVF_CAP: begin
          if (!state_reg.ramp_direction && timer_overflow_flag) begin
            state_next.ramp_direction = 1'b1; // R9 R22
          end else if (state_reg.ramp_direction && capture_event_flag) begin
            state_next.ramp_direction = 1'b0; // R9 R22
          end
        end
        SSAC_MODE_CMP_CAP: begin
          if (!state_reg.ramp_direction && compare_match_flag) begin
            state_next.ramp_direction = 1'b1; // R10 R22
          end else if (state_reg.ramp_direction && capture_event_flag) begin
            state_next.ramp_direction = 1'b0; // R10 R22
          end
        end
      endcase
    end

    // Software write to the control word wins over hardware
    if (wr_acr) begin
      state_next.ramp_direction        = wbyte[`SSAC_BIT_RAMP_DIR]; // R7 R22
      state_next.conv_mode_high        = wbyte[`SSAC_BIT_MODE_HIGH];
      state_next.conv_mode_low         = wbyte[`SSAC_BIT_MODE_LOW];
      // Selecting a timer mode forces capture from flag two
      state_next.capture_route_select  = wbyte[`SSAC_BIT_ROUTE] |
                                         wbyte[`SSAC_BIT_MODE_HIGH]; // R12
      state_next.comparator_irq_enable = wbyte[`SSAC_BIT_IRQ_EN];
      state_next.comparator_two_power  = wbyte[`SSAC_BIT_CP2_PWR];  // R17
      state_next.comparator_one_power  = wbyte[`SSAC_BIT_CP1_PWR];  // R17
      state_next.current_source_power  = wbyte[`SSAC_BIT_ISRC_PWR]; // R18
    end

    // Ramp pin drive follows the new bits in the same edge;
    // clearing source power stops both at once.
    state_next.ramp_source_en = state_next.current_source_power &
                                state_next.ramp_direction;           // R3 R4
    state_next.ramp_sink_en   = state_next.current_source_power &
                                ~state_next.ramp_direction;          // R3 R4 R18

    // Shared support circuitry
    state_next.support_power  = state_next.current_source_power |
                                state_next.comparator_one_power |
                                state_next.comparator_two_power;     // R19

    // Timer capture source; the timer itself stores the count and
    // must be set to rising edges by software.
    state_next.capture_input  = state_next.capture_route_select ?
                                state_next.comparator_two_flag :
                                extcap_level; // R11 R13

    // Analog request tracks the sticky flags, independent of the
    // timer capture flag, so it stays pending after that is cleared.
    state_next.analog_irq     = state_next.comparator_irq_enable &
                                (state_next.comparator_one_flag |
                                 state_next.comparator_two_flag);    // R15 R16
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset clears all control bits: everything powered down, manual
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0; // R1
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flop
  // ----------------------------------------------------------------
  assign prdata                  = state_reg.prdata;
  assign pready                  = state_reg.pready;
  assign pslverr                 = state_reg.pslverr;
  assign comparator_one_power_en = state_reg.comparator_one_power;  // R17
  assign comparator_two_power_en = state_reg.comparator_two_power;  // R17
  assign current_source_power_en = state_reg.current_source_power;  // R18
  assign support_power_en        = state_reg.support_power;
  assign ramp_source_en          = state_reg.ramp_source_en;
  assign ramp_sink_en            = state_reg.ramp_sink_en;
  assign timer_capture_input     = state_reg.capture_input;
  assign analog_irq              = state_reg.analog_irq;

endmodule

// ---- verif/ssac_checker.sv ----
`timescale 1ns/1ns
// ------------------------------
// Port checks for the control block
// ------------------------------
module ssac_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              timer_overflow_flag,
  input wire logic              compare_match_flag,
  input wire logic              comparator_one_power_en,
  input wire logic              comparator_two_power_en,
  input wire logic              current_source_power_en,
  input wire logic              support_power_en,
  input wire logic              ramp_source_en,
  input wire logic              ramp_sink_en
);
  logic wr_acr;  // Control write lands at this edge
  logic mapped;  // Address hits one of the two words
  assign wr_acr = psel && penable && pready && pwrite && paddr == ADDR_W'(8'h74);
  assign mapped = paddr == ADDR_W'(8'h74) || paddr == ADDR_W'(8'h78);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_support; support_power_en == (comparator_one_power_en || comparator_two_power_en
    || current_source_power_en); endproperty
  a_support: assert property (p_support) else $error("support power mismatch");
  property p_src; ramp_source_en |-> current_source_power_en && !ramp_sink_en; endproperty
  a_src: assert property (p_src) else $error("source without power");
  property p_sink; ramp_sink_en |-> current_source_power_en; endproperty
  a_sink: assert property (p_sink) else $error("sink without power");
  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("answer timing wrong");
  property p_err; pready && !mapped |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  property p_pwr; wr_acr |=> current_source_power_en == $past(pwdata[0])
    && comparator_one_power_en == $past(pwdata[1]) && comparator_two_power_en == $past(pwdata[2]); endproperty
  a_pwr: assert property (p_pwr) else $error("power bits not written");
  property p_dir; wr_acr && pwdata[0] |=> ramp_source_en == $past(pwdata[7]); endproperty
  a_dir: assert property (p_dir) else $error("direction write lost");
  property p_rise; $rose(ramp_source_en) |-> $past(wr_acr || timer_overflow_flag || compare_match_flag);
  endproperty
  a_rise: assert property (p_rise) else $error("charge began without cause");
endmodule

bind ssac_top ssac_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- verif/ssac_analog_model.sv ----
`timescale 1ns/1ns
// ------------------------------
// Ramp capacitor, comparator two and timer capture
// ------------------------------
module ssac_analog_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ramp_source_en,
  input  wire logic       ramp_sink_en,
  input  wire logic       comparator_two_power_en,
  input  wire logic       timer_capture_input,
  input  wire logic [7:0] ramp_target,
  output logic            comparator_two_out,
  output logic            capture_event_flag
);
  logic [7:0] ramp_reg;  // Capacitor voltage in steps
  logic       cap_reg;   // Last capture input level
  // Charge one step a cycle, discharge at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_reg <= 8'h00;
      cap_reg  <= 1'b0;
    end else begin
      if (ramp_sink_en) begin
        ramp_reg <= 8'h00;
      end else if (ramp_source_en && ramp_reg != 8'hff) begin
        ramp_reg <= ramp_reg + 8'h01;
      end
      cap_reg <= timer_capture_input;
    end
  end
  // Unpowered comparator reads low
  assign comparator_two_out = comparator_two_power_en && ramp_reg > ramp_target;
  // Edge select set to rising, so only a rise captures
  assign capture_event_flag = timer_capture_input && !cap_reg;
endmodule

// ---- verif/tb_single_slope_adc_control.sv ----
`timescale 1ns/1ns
module tb_single_slope_adc_control;
  localparam logic [7:0] ANALOG_CONTROL = 8'h74, FLG = 8'h78;  // Byte addresses
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, comparator_one_out, comparator_two_out;
  logic external_capture_pin, timer_overflow_flag, compare_match_flag, capture_event_flag, analog_irq;
  logic comparator_one_power_en, comparator_two_power_en, current_source_power_en, support_power_en;
  logic ramp_source_en, ramp_sink_en, timer_capture_input;
  logic [7:0] paddr, ramp_target, v;
  logic [31:0] pwdata, prdata, r;
  logic e;
  int failures = 0, num_checks = 0, cyc = 0;
  ssac_top dut (.*);
  ssac_analog_model u_far (.*);
  // ------------------------------
  // Helpers
  // ------------------------------
  task test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Setup, then hold until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin failures++; test_done(); end
    r = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  // One-cycle timer event, then let outputs land
  task pulse(input logic cmp);
    @(posedge pclk);
    if (cmp) compare_match_flag <= 1'b1; else timer_overflow_flag <= 1'b1;
    @(posedge pclk);
    compare_match_flag <= 1'b0; timer_overflow_flag <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_src(input logic lvl);
    for (int n = 0; n < 400 && ramp_source_en !== lvl; n++) @(posedge pclk);
  endtask
  // Mode high bit drags the route bit along
  function logic [31:0] exp_acr(input logic [7:0] w);
    return {24'h0, w | (w[6] ? 8'h10 : 8'h00)};
  endfunction
  function logic [31:0] exp_out(input logic [7:0] w);
    return {26'h0, w[0] & w[7], w[0] & ~w[7], |w[2:0], w[2], w[1], w[0]};
  endfunction
  function logic [31:0] outs();
    return {26'h0, ramp_source_en, ramp_sink_en, support_power_en, comparator_two_power_en,
      comparator_one_power_en, current_source_power_en};
  endfunction
  // ------------------------------
  // Clock, reset and watchdog
  // ------------------------------
  initial begin pclk = 1'b0; forever #25 pclk = ~pclk; end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin failures++; test_done(); end
  end
  initial begin
    {presetn, psel, penable, pwrite, comparator_one_out, external_capture_pin} = '0;
    {timer_overflow_flag, compare_match_flag, paddr, pwdata} = '0;
    ramp_target = 8'hff;  // Comparator never trips while set high
    void'($urandom(32'h03878ec9));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ANALOG_CONTROL, 0); check(r, 32'h0); check(outs(), 32'h0);
    apb(0, FLG, 0); check(r, 32'h0);
    $display("end reset");
    // Random control values, corners first
    for (int i = 0; i < 18; i++) begin
      v = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
      comparator_one_out <= 1'($urandom);
      apb(1, ANALOG_CONTROL, {24'($urandom), v});
      apb(0, ANALOG_CONTROL, 0); check(r, exp_acr(v));
      check(outs(), exp_out(v));
    end
    apb(1, 8'h7c, 32'h0); check(e, 1);
    apb(0, 8'h7c, 0); check(e, 1); check(r, 0);
    $display("end random");
    // Manual charge, discharge on flag two
    comparator_one_out <= 1'b0; apb(1, ANALOG_CONTROL, 8'h05); ramp_target <= 8'h20;
    apb(1, FLG, 3); apb(1, ANALOG_CONTROL, 8'haf);
    wait_src(1); wait_src(0);
    apb(0, ANALOG_CONTROL, 0); check(r, 32'h2f);
    apb(0, FLG, 0); check(r, 32'h2); check(analog_irq, 1);
    apb(1, FLG, 0); apb(0, FLG, 0); check(r, 32'h2);
    apb(1, FLG, 2); apb(0, FLG, 0); check(r, 32'h0); check(analog_irq, 0);
    $display("end auto discharge");
    // Timer modes: wrong event ignored, right one charges, capture stops
    for (int m = 0; m < 2; m++) begin
      v = m ? 8'h6f : 8'h4f;
      apb(1, ANALOG_CONTROL, v); apb(0, ANALOG_CONTROL, 0); check(r, exp_acr(v));
      pulse(m == 0); check(ramp_source_en, 0);
      pulse(m == 1); check(ramp_source_en, 1);
      wait_src(0);
      apb(0, ANALOG_CONTROL, 0); check(r, exp_acr(v));
      check(timer_capture_input, 1); check(analog_irq, 1);
      apb(1, FLG, 2);
    end
    $display("end timer modes");
    // Unpowered source ignores events; manual ignores them too
    apb(1, ANALOG_CONTROL, 8'h40); pulse(0); check(outs(), 32'h0);
    apb(0, ANALOG_CONTROL, 0); check(r, 32'h50);
    apb(1, ANALOG_CONTROL, 8'h81); pulse(0); pulse(1); apb(0, ANALOG_CONTROL, 0); check(r, 32'h81);
    apb(1, ANALOG_CONTROL, 8'h00); external_capture_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    check(timer_capture_input, 1);
    external_capture_pin <= 1'b0;
    $display("end route and manual");
    // Reset in mid-run
    apb(1, ANALOG_CONTROL, 8'hff); presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1; check(outs(), 32'h0);
    apb(0, ANALOG_CONTROL, 0); check(r, 32'h0);
    $display("end second reset");
    test_done();
  end
endmodule
